// [src/nvc_pkg.sv]
`default_nettype none
package nvc_pkg;

   // Special-function register addresses seen by the core
   localparam logic [7:0] ADDR_NVM_ADDRESS = 8'h1a;
   localparam logic [7:0] ADDR_NVM_DATA_BYTE = 8'h1b;
   localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
   localparam logic [7:0] ADDR_INDIRECT_POINTER = 8'h03;
   localparam logic [7:0] ADDR_INDIRECT_ACCESS_PORT = 8'h02;
   localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0e;
   localparam logic [7:0] ADDR_NVM_CONTROL = 8'h40;
   localparam logic [7:0] BANK_NVM_CONTROL = 8'h01;

   // Control register fields
   localparam int CTL_STORE_PERMIT = 3;
   localparam int CTL_STORE_START = 2;
   localparam int CTL_FETCH_PERMIT = 1;
   localparam int CTL_FETCH_START = 0;
   localparam logic [3:0] CTL_RESET = 4'h0;
   localparam logic [7:0] BANK_RESET = 8'h00;
   localparam logic [7:0] PTR_RESET = 8'h00;

   // Interrupt control fields
   localparam int IRQ_GLOBAL_ON = 0;
   localparam int IRQ_MF_ON = 1;
   localparam int IRQ_DONE_ON = 2;
   localparam int IRQ_MF_FLAG = 3;
   localparam int IRQ_DONE_FLAG = 4;
   localparam logic [4:0] IRQ_RESET = 5'h00;

   // Timing
   localparam int FETCH_TIME_NS = 20;
   localparam int CLK_PERIOD_NS = 10;
   localparam int FETCH_CYCLES = (FETCH_TIME_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } nvc_sfr_req_t;

   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } nvc_mem_req_t;

endpackage : nvc_pkg
`default_nettype wire

// [src/nvc_mem.sv]
`timescale 1ns/1ns
`default_nettype none
// Byte array model of the cell array; read data registered
module nvc_mem #(
   parameter int AW = 8
)
(
   // Clock
   input wire logic clk,
   // Access
   input wire nvc_pkg::nvc_mem_req_t req,
   input wire logic en,
   output logic [7:0] rdata
);

   logic [7:0] cells_ff [0:(1 << AW) - 1];

   always_ff @(posedge clk)
   begin
      if (en && req.we)
      begin
         cells_ff[req.addr[AW-1:0]] <= req.wdata;
      end
      if (en && !req.we)
      begin
         rdata <= cells_ff[req.addr[AW-1:0]];
      end
   end

endmodule : nvc_mem
`default_nettype wire

// [src/nvc_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module nvc_ctrl #(
   parameter int AW = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Core special-function register access
   input wire nvc_pkg::nvc_sfr_req_t sfr,
   output logic [7:0] sfr_rdata,
   // Asynchronous write timer
   output logic timer_start,
   input wire logic timer_done,
   // Interrupt handshake with the core
   input wire logic stack_full,
   input wire logic irq_serviced,
   output logic irq_vector_req
);

   typedef enum {NVC_IDLE, NVC_FETCH, NVC_FETCH_END, NVC_STORE,
      NVC_STORE_WAIT} nvc_state_t;

   nvc_state_t state_ff;
   logic [AW-1:0] addr_ff;
   logic [7:0] data_ff;
   logic [7:0] bank_ff;
   logic [7:0] ptr_ff;
   logic [3:0] ctl_ff;
   logic [4:0] irq_ff;
   logic [AW-1:0] cyc_addr_ff;
   logic [7:0] cyc_data_ff;
   logic [3:0] cnt_ff;
   logic done_sync1_ff;
   logic done_sync2_ff;
   logic done_prev_ff;
   logic [7:0] mem_rdata;
   logic mem_en;
   logic ctl_sel;
   logic [3:0] ctl_wr;
   logic fetch_go;
   logic store_go;
   logic cycle_end;
   logic timer_edge;
   nvc_pkg::nvc_mem_req_t mem_req;

   // Control register is only visible through the indirect port
   assign ctl_sel = sfr.addr == nvc_pkg::ADDR_INDIRECT_ACCESS_PORT &&
      ptr_ff == nvc_pkg::ADDR_NVM_CONTROL &&
      bank_ff == nvc_pkg::BANK_NVM_CONTROL;
   assign ctl_wr = sfr.wdata[3:0];

   // Start only honoured if its permit was already set beforehand
   assign fetch_go = state_ff == NVC_IDLE && sfr.wr && ctl_sel &&
      ctl_wr[nvc_pkg::CTL_FETCH_START] &&
      !ctl_ff[nvc_pkg::CTL_FETCH_START] &&
      ctl_ff[nvc_pkg::CTL_FETCH_PERMIT];
   assign store_go = state_ff == NVC_IDLE && sfr.wr && ctl_sel &&
      ctl_wr[nvc_pkg::CTL_STORE_START] &&
      !ctl_ff[nvc_pkg::CTL_STORE_START] &&
      ctl_ff[nvc_pkg::CTL_STORE_PERMIT] && !fetch_go;

   assign timer_edge = done_sync2_ff && !done_prev_ff;
   assign cycle_end = state_ff == NVC_FETCH_END ||
      (state_ff == NVC_STORE_WAIT && timer_edge);

   // Timer completion is asynchronous: two-stage synchroniser
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         done_sync1_ff <= 1'b0;
         done_sync2_ff <= 1'b0;
         done_prev_ff <= 1'b0;
      end
      else
      begin
         done_sync1_ff <= timer_done;
         done_sync2_ff <= done_sync1_ff;
         done_prev_ff <= done_sync2_ff;
      end
   end

   // Directly mapped registers; address/data power up undefined
   always_ff @(posedge clk)
   begin
      if (sfr.wr && sfr.addr == nvc_pkg::ADDR_NVM_ADDRESS)
      begin
         addr_ff <= sfr.wdata[AW-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (state_ff == NVC_FETCH_END)
      begin
         data_ff <= mem_rdata;
      end
      else if (sfr.wr && sfr.addr == nvc_pkg::ADDR_NVM_DATA_BYTE)
      begin
         data_ff <= sfr.wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bank_ff <= nvc_pkg::BANK_RESET;
         ptr_ff <= nvc_pkg::PTR_RESET;
      end
      else
      begin
         if (sfr.wr && sfr.addr == nvc_pkg::ADDR_BANK_SELECT)
         begin
            bank_ff <= sfr.wdata;
         end
         if (sfr.wr && sfr.addr == nvc_pkg::ADDR_INDIRECT_POINTER)
         begin
            ptr_ff <= sfr.wdata;
         end
      end
   end

   // Control register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctl_ff <= nvc_pkg::CTL_RESET;
      end
      else
      begin
         if (sfr.wr && ctl_sel)
         begin
            ctl_ff[nvc_pkg::CTL_STORE_PERMIT] <=
               ctl_wr[nvc_pkg::CTL_STORE_PERMIT];
            ctl_ff[nvc_pkg::CTL_FETCH_PERMIT] <=
               ctl_wr[nvc_pkg::CTL_FETCH_PERMIT];
            // Software cannot clear a start bit mid-cycle
            if (state_ff == NVC_IDLE)
            begin
               ctl_ff[nvc_pkg::CTL_FETCH_START] <= fetch_go;
               ctl_ff[nvc_pkg::CTL_STORE_START] <= store_go;
            end
         end
         if (cycle_end)
         begin
            ctl_ff[nvc_pkg::CTL_FETCH_START] <= 1'b0;
            ctl_ff[nvc_pkg::CTL_STORE_START] <= 1'b0;
         end
      end
   end

   // Latch address and data so later register writes cannot corrupt
   always_ff @(posedge clk)
   begin
      if (fetch_go || store_go)
      begin
         cyc_addr_ff <= addr_ff;
         cyc_data_ff <= data_ff;
      end
   end

   // Cycle sequencer
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_ff <= NVC_IDLE;
         cnt_ff <= 4'h0;
      end
      else
      begin
         unique case (state_ff)
            NVC_IDLE:
            begin
               cnt_ff <= 4'h0;
               if (fetch_go)
               begin
                  state_ff <= NVC_FETCH;
               end
               else if (store_go)
               begin
                  state_ff <= NVC_STORE;
               end
            end
            NVC_FETCH:
            begin
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'(nvc_pkg::FETCH_CYCLES - 1))
               begin
                  state_ff <= NVC_FETCH_END;
               end
            end
            NVC_FETCH_END:
            begin
               state_ff <= NVC_IDLE;
            end
            NVC_STORE:
            begin
               state_ff <= NVC_STORE_WAIT;
            end
            NVC_STORE_WAIT:
            begin
               if (timer_edge)
               begin
                  state_ff <= NVC_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         timer_start <= 1'b0;
      end
      else
      begin
         timer_start <= state_ff == NVC_STORE ||
            (state_ff == NVC_STORE_WAIT && !done_sync2_ff &&
            timer_start);
      end
   end

   // Commit on store entry, fetch on first fetch cycle
   assign mem_en = state_ff == NVC_STORE ||
      (state_ff == NVC_FETCH && cnt_ff == 4'h0);
   assign mem_req.we = state_ff == NVC_STORE;
   assign mem_req.addr = 8'(cyc_addr_ff);
   assign mem_req.wdata = cyc_data_ff;

   nvc_mem #(.AW(AW)) u_mem (
      .clk(clk),
      .req(mem_req),
      .en(mem_en),
      .rdata(mem_rdata)
   );

   // Interrupt bits; a cycle end beats a software clear
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_ff <= nvc_pkg::IRQ_RESET;
      end
      else
      begin
         if (sfr.wr && sfr.addr == nvc_pkg::ADDR_IRQ_CTRL)
         begin
            irq_ff <= sfr.wdata[4:0];
         end
         if (irq_serviced)
         begin
            irq_ff[nvc_pkg::IRQ_MF_FLAG] <= 1'b0;
         end
         if (cycle_end)
         begin
            irq_ff[nvc_pkg::IRQ_DONE_FLAG] <= 1'b1;
            irq_ff[nvc_pkg::IRQ_MF_FLAG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_vector_req <= 1'b0;
      end
      else
      begin
         irq_vector_req <= irq_ff[nvc_pkg::IRQ_MF_FLAG] &&
            irq_ff[nvc_pkg::IRQ_DONE_FLAG] &&
            irq_ff[nvc_pkg::IRQ_DONE_ON] &&
            irq_ff[nvc_pkg::IRQ_MF_ON] &&
            irq_ff[nvc_pkg::IRQ_GLOBAL_ON] &&
            !stack_full && !irq_serviced;
      end
   end

   // Read mux, registered
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sfr_rdata <= 8'h00;
      end
      else if (sfr.rd)
      begin
         sfr_rdata <= 8'h00;
         if (sfr.addr == nvc_pkg::ADDR_NVM_ADDRESS)
         begin
            sfr_rdata <= 8'(addr_ff);
         end
         else if (sfr.addr == nvc_pkg::ADDR_NVM_DATA_BYTE)
         begin
            sfr_rdata <= data_ff;
         end
         else if (sfr.addr == nvc_pkg::ADDR_BANK_SELECT)
         begin
            sfr_rdata <= bank_ff;
         end
         else if (sfr.addr == nvc_pkg::ADDR_INDIRECT_POINTER)
         begin
            sfr_rdata <= ptr_ff;
         end
         else if (sfr.addr == nvc_pkg::ADDR_IRQ_CTRL)
         begin
            sfr_rdata <= {3'h0, irq_ff};
         end
         else if (ctl_sel)
         begin
            sfr_rdata <= {4'h0, ctl_ff};
         end
      end
   end

endmodule : nvc_ctrl
`default_nettype wire

// [tb/nvc_timer_model.sv]
`timescale 1ns/1ns
`default_nettype none
module nvc_timer_model
(
   // Request from the controller
   input wire logic timer_start,
   input wire logic slow,
   // Completion back to the controller
   output var logic timer_done
);
   // Odd delays keep completion off the clock grid
   initial
   begin
      timer_done = 1'b0;
      forever
      begin
         @(posedge timer_start);
         #(slow ? 733 : 37);
         timer_done = timer_start;
         // Completion stays up until the controller drops its request
         wait (!timer_start);
         timer_done = 1'b0;
      end
   end
endmodule : nvc_timer_model
`default_nettype wire

// [tb/nvc_ctrl_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module nvc_ctrl_chk #(
   parameter int AW = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register access
   input wire nvc_pkg::nvc_sfr_req_t sfr,
   input wire logic [7:0] sfr_rdata,
   // Timer and interrupt
   input wire logic timer_start,
   input wire logic timer_done,
   input wire logic stack_full,
   input wire logic irq_serviced,
   input wire logic irq_vector_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic go;
   assign go = sfr.wr && sfr.wdata[2] &&
      sfr.addr == nvc_pkg::ADDR_INDIRECT_ACCESS_PORT;
   sequence s_serv;
      irq_serviced && !timer_start ##1 1'b1;
   endsequence
   property p_start_cause;
      $rose(timer_start) |-> $past(go) || $past(go, 2);
   endproperty
   property p_start_hold;
      timer_start && !timer_done |=> timer_start;
   endproperty
   property p_start_drop;
      $fell(timer_start) |-> $past(timer_done);
   endproperty
   property p_stack_block;
      stack_full |=> !irq_vector_req;
   endproperty
   property p_serv_clear;
      s_serv |=> !irq_vector_req;
   endproperty
   property p_rdata_hold;
      !sfr.rd |=> $stable(sfr_rdata);
   endproperty
   property p_addr_upper;
      sfr.rd && sfr.addr == nvc_pkg::ADDR_NVM_ADDRESS |=>
         (sfr_rdata >> AW) == 8'h00;
   endproperty
   property p_ctl_upper;
      sfr.rd && sfr.addr == nvc_pkg::ADDR_INDIRECT_ACCESS_PORT |=>
         sfr_rdata[7:4] == 4'h0;
   endproperty
   a_start_cause: assert property (p_start_cause)
      else $error("timer started without store request");
   a_start_hold: assert property (p_start_hold)
      else $error("timer request dropped early");
   a_start_drop: assert property (p_start_drop)
      else $error("timer request dropped before completion");
   a_stack_block: assert property (p_stack_block)
      else $error("vector request with stack full");
   a_serv_clear: assert property (p_serv_clear)
      else $error("vector request after service");
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without read");
   a_addr_upper: assert property (p_addr_upper)
      else $error("address upper bits not zero");
   a_ctl_upper: assert property (p_ctl_upper)
      else $error("control upper bits not zero");
endmodule : nvc_ctrl_chk
bind nvc_ctrl nvc_ctrl_chk #(.AW(AW)) u_chk (.clk(clk), .nrst(nrst),
   .sfr(sfr), .sfr_rdata(sfr_rdata), .timer_start(timer_start),
   .timer_done(timer_done), .stack_full(stack_full),
   .irq_serviced(irq_serviced), .irq_vector_req(irq_vector_req));
`default_nettype wire

// [tb/nvc_ctrl_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module nvc_ctrl_bench;
   localparam int AW = 5;
   localparam logic [7:0] PORT = nvc_pkg::ADDR_INDIRECT_ACCESS_PORT;
   localparam logic [7:0] ADR = nvc_pkg::ADDR_NVM_ADDRESS;
   localparam logic [7:0] DAT = nvc_pkg::ADDR_NVM_DATA_BYTE;
   localparam logic [7:0] IRQ = nvc_pkg::ADDR_IRQ_CTRL;
   logic clk, nrst, stack_full, irq_serviced, slow;
   logic timer_start, timer_done, irq_vector_req;
   nvc_pkg::nvc_sfr_req_t sfr;
   logic [7:0] sfr_rdata, v;
   int n_mismatch, check_count;
   nvc_ctrl #(.AW(AW)) uut (.clk(clk), .nrst(nrst), .sfr(sfr),
      .sfr_rdata(sfr_rdata), .timer_start(timer_start),
      .timer_done(timer_done), .stack_full(stack_full),
      .irq_serviced(irq_serviced), .irq_vector_req(irq_vector_req));
   nvc_timer_model u_tmr (.timer_start(timer_start), .slow(slow),
      .timer_done(timer_done));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
      check_count++;
      if (seen !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, seen);
      end
   endtask : chk
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 sfr = {1'b1, 1'b0, a, d};
      @(posedge clk);
      #1 sfr = '0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge clk);
      #1 sfr = {1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      #1 sfr = '0;
      @(posedge clk);
      #1 v = sfr_rdata;
   endtask : rd
   task poll(input int b);
      for (int i = 0; i < 300; i++)
      begin
         rd(PORT);
         if (v[b] === 1'b0)
            break;
      end
      chk("cycle end", v & (8'h01 << b), 8'h00);
   endtask : poll
   task store(input logic [7:0] a, input logic [7:0] d);
      wr(ADR, a);
      wr(DAT, d);
      wr(PORT, 8'h08);
      wr(PORT, 8'h0c);
      // Disturb the registers while the cycle runs
      wr(ADR, ~a);
      wr(DAT, ~d);
      poll(2);
   endtask : store
   task fetch(input logic [7:0] a, input logic [7:0] e);
      wr(ADR, a);
      wr(PORT, 8'h02);
      wr(PORT, 8'h03);
      poll(0);
      rd(DAT);
      chk("fetched", v, e);
   endtask : fetch
   task t_reset;
      rd(nvc_pkg::ADDR_BANK_SELECT);
      chk("bank", v, nvc_pkg::BANK_RESET);
      wr(PORT, 8'h08);
      wr(nvc_pkg::ADDR_INDIRECT_POINTER, 8'h40);
      wr(nvc_pkg::ADDR_BANK_SELECT, nvc_pkg::BANK_NVM_CONTROL);
      rd(PORT);
      chk("control", v, 8'h00);
   endtask : t_reset
   task t_store_fetch;
      slow = 1'b1;
      store(8'h1f, 8'ha5);
      slow = 1'b0;
      store(8'h00, 8'h3c);
      fetch(8'h1f, 8'ha5);
      fetch(8'h00, 8'h3c);
   endtask : t_store_fetch
   task t_guard;
      wr(DAT, 8'h77);
      wr(PORT, 8'h00);
      wr(PORT, 8'h04);
      wr(PORT, 8'h01);
      rd(PORT);
      chk("blocked", v, 8'h00);
      chk("timer", {7'h00, timer_start}, 8'h00);
      rd(DAT);
      chk("data kept", v, 8'h77);
      fetch(8'h00, 8'h3c);
   endtask : t_guard
   task t_addr;
      wr(ADR, 8'hff);
      rd(ADR);
      chk("address", v, 8'((1 << AW) - 1));
   endtask : t_addr
   task t_irq;
      stack_full = 1'b1;
      wr(IRQ, 8'h06);
      store(8'h05, 8'h11);
      rd(IRQ);
      chk("flags", v, 8'h1e);
      wr(IRQ, 8'h1f);
      repeat (3) @(posedge clk);
      #1 chk("stack full", {7'h00, irq_vector_req}, 8'h00);
      stack_full = 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("vector", {7'h00, irq_vector_req}, 8'h01);
      irq_serviced = 1'b1;
      @(posedge clk);
      #1 irq_serviced = 1'b0;
      chk("vector off", {7'h00, irq_vector_req}, 8'h00);
      rd(IRQ);
      chk("serviced", v, 8'h17);
      wr(IRQ, 8'h07);
      rd(IRQ);
      chk("cleared", v, 8'h07);
   endtask : t_irq
   initial
   begin
      sfr = '0;
      nrst = 1'b0;
      stack_full = 1'b0;
      irq_serviced = 1'b0;
      slow = 1'b0;
      n_mismatch = 0;
      check_count = 0;
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      t_reset;
      t_store_fetch;
      t_guard;
      t_addr;
      t_irq;
      print_verdict;
   end
   initial
   begin
      #200000;
      n_mismatch++;
      print_verdict;
   end
endmodule : nvc_ctrl_bench
`default_nettype wire
